/* File: rtl/core_mem_pkg.sv */
// constants for the core memory map and flags register block
// assumes a single core clock and an 8-bit data path
package core_mem_pkg;
    localparam int PC_W = 13;
    localparam int PROG_WORD_W = 14;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam int PROG_WORDS_SMALL = 256;
    localparam int PROG_WORDS_LARGE = 512;
    localparam int DATA_AW = 7;
    localparam logic [6:0] FLAGS_ADDR = 7'h03;
    localparam logic [6:0] POINTER_ADDR = 7'h04;
    localparam logic [6:0] INDIRECT_ADDR = 7'h00;
    localparam logic [6:0] GPR_BASE = 7'h40;
    localparam int GPR_DEPTH = 64;
    localparam int BIT_UPPER_PAGE = 7;
    localparam int BIT_BANK_HIGH = 6;
    localparam int BIT_BANK_LOW = 5;
    localparam int BIT_WDT_N = 4;
    localparam int BIT_SLEEP_N = 3;
    localparam int BIT_ZERO = 2;
    localparam int BIT_NIBBLE = 1;
    localparam int BIT_CARRY = 0;
    localparam logic [1:0] BANK_ZERO = 2'h0;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    typedef enum logic [2:0] {
        ALU_NONE = 3'b000,
        ALU_ADD = 3'b001,
        ALU_SUB = 3'b010,
        ALU_LOGIC = 3'b011,
        ALU_RRF = 3'b100,
        ALU_RLF = 3'b101
    } alu_op_t;
endpackage

/* File: rtl/core_memory_map_status.sv */
// program counter, data bank decode, general RAM and core flags register
// assumes the instruction execution logic drives one request per clock
//
// What this block does
// - program counter is 13 bits, spanning 8K words of 14 bits
// - only 256 or 512 words implemented, chosen by parameter
// - fetches above implemented memory wrap; only low bits decoded
// - reset starts at 0000h; taken interrupt loads 0004h
// - one 128-byte data bank, special registers low, RAM above
// - 64-byte general RAM reached directly or via indirect pointer
// - bank select pair chooses bank; 00 is the only bank
// - add, subtract, logic writing flags register ignore Z, DC, C; rotates ignore only C
// - watchdog and sleep flags read-only to instruction writes
// - watchdog flag set on power-up, kick, sleep; cleared on time-out
// - sleep flag set on power-up and kick; cleared on sleep
// - zero flag set when result is zero, else cleared
// - add and subtract set nibble carry from bit 3 carry-out
// - add and subtract set carry from bit 7 carry-out
// - subtract adds two's complement; carries act as inverted borrow
// - rotates load carry with shifted-out low or high bit
// - reset values: selects 0, watchdog and sleep 1 on power-on reset only, arithmetic kept
// - flags register writable by any instruction except protected bits and the Z, DC, C cases above
`timescale 1ns/10ps
module core_memory_map_status #(
    parameter int PROG_WORDS = core_mem_pkg::PROG_WORDS_LARGE
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic power_on_in,
    input wire logic pc_load_in,
    input wire logic [12:0] pc_load_value_in,
    input wire logic pc_advance_in,
    input wire logic irq_take_in,
    output logic [12:0] pc_out,
    output logic [12:0] fetch_addr_out,
    input wire logic [6:0] data_addr_in,
    input wire logic data_wr_in,
    input wire logic [7:0] data_wdata_in,
    output logic [7:0] data_rdata_out,
    output logic data_hit_out,
    input wire core_mem_pkg::alu_op_t alu_op_in,
    input wire logic [7:0] alu_a_in,
    input wire logic [7:0] alu_b_in,
    input wire logic alu_carry_in,
    output logic [7:0] alu_result_out,
    input wire logic watchdog_kick_op_in,
    input wire logic sleep_op_in,
    input wire logic watchdog_timeout_in,
    output logic [7:0] core_flags_out
);
    import core_mem_pkg::*;

    localparam int PROG_AW = $clog2(PROG_WORDS);

    logic [12:0] pc;
    logic [7:0] indirect_pointer;
    logic [7:0] general_ram_file [GPR_DEPTH];
    logic upper_page_select;
    logic [1:0] bank_select_pair;
    logic watchdog_expiry_flag_n;
    logic sleep_flag_n;
    logic zero_flag;
    logic nibble_overflow_flag;
    logic carry_flag;
    logic [6:0] eff_addr;
    logic flags_sel;
    logic ram_sel;
    logic [5:0] ram_index;
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] operand_b;
    logic carry_seed;
    logic [7:0] next_result;
    logic next_zero;
    logic next_nibble;
    logic next_carry;
    logic updates_zdc;
    logic updates_carry;
    logic flags_wr;

    // wrap onto the implemented words by masking high bits
    function automatic logic [12:0] wrap_fetch(input logic [12:0] addr);
        logic [12:0] mask;
        mask = 13'(PROG_WORDS - 1);
        wrap_fetch = addr & mask;
    endfunction

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pc <= RESET_VECTOR;
        end else if (irq_take_in) begin
            pc <= IRQ_VECTOR;
        end else if (pc_load_in) begin
            pc <= pc_load_value_in;
        end else if (pc_advance_in) begin
            pc <= pc + 13'h0001;
        end
    end

    assign pc_out = pc;
    assign fetch_addr_out = wrap_fetch(pc);

    // indirect slot reads through the pointer; only bank 0 exists
    assign eff_addr = (data_addr_in == INDIRECT_ADDR) ? indirect_pointer[6:0]
                                                      : data_addr_in;
    assign flags_sel = (eff_addr == FLAGS_ADDR) && (bank_select_pair == BANK_ZERO);
    assign ram_sel = (eff_addr >= GPR_BASE) && (bank_select_pair == BANK_ZERO);
    assign ram_index = eff_addr[5:0];
    assign data_hit_out = flags_sel || ram_sel || (eff_addr == POINTER_ADDR);

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            indirect_pointer <= POINTER_RESET;
        end else if (data_wr_in && eff_addr == POINTER_ADDR) begin
            indirect_pointer <= data_wdata_in;
        end
    end

    // ram contents are not reset, matching static RAM
    always_ff @(posedge ref_clk_in) begin
        if (data_wr_in && ram_sel) begin
            general_ram_file[ram_index] <= data_wdata_in;
        end
    end

    // combinational read so a prior write is seen at once
    always_comb begin
        if (flags_sel) begin
            data_rdata_out = core_flags_out;
        end else if (ram_sel) begin
            data_rdata_out = general_ram_file[ram_index];
        end else if (eff_addr == POINTER_ADDR) begin
            data_rdata_out = indirect_pointer;
        end else begin
            data_rdata_out = 8'h00;
        end
    end

    always_comb begin
        operand_b = (alu_op_in == ALU_SUB) ? ~alu_b_in : alu_b_in;
        carry_seed = (alu_op_in == ALU_SUB) ? 1'b1 : 1'b0;
        sum = {1'b0, alu_a_in} + {1'b0, operand_b} + {8'h00, carry_seed};
        low_sum = {1'b0, alu_a_in[3:0]} + {1'b0, operand_b[3:0]} + {4'h0, carry_seed};
        next_nibble = low_sum[4];
        next_carry = sum[8];
        updates_zdc = 1'b0;
        updates_carry = 1'b0;
        case (alu_op_in)
            ALU_ADD, ALU_SUB: begin
                next_result = sum[7:0];
                updates_zdc = 1'b1;
                updates_carry = 1'b1;
            end
            ALU_LOGIC: begin
                next_result = alu_b_in;
                updates_zdc = 1'b1;
            end
            ALU_RRF: begin
                next_result = {alu_carry_in, alu_a_in[7:1]};
                next_carry = alu_a_in[0];
                updates_carry = 1'b1;
            end
            ALU_RLF: begin
                next_result = {alu_a_in[6:0], alu_carry_in};
                next_carry = alu_a_in[7];
                updates_carry = 1'b1;
            end
            default: begin
                next_result = alu_a_in;
            end
        endcase
        next_zero = (next_result == 8'h00);
    end

    assign alu_result_out = next_result;
    assign flags_wr = data_wr_in && flags_sel;

    // select bits are cleared by every reset
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            upper_page_select <= 1'b0;
            bank_select_pair <= BANK_ZERO;
        end else if (flags_wr) begin
            upper_page_select <= data_wdata_in[BIT_UPPER_PAGE];
            bank_select_pair <= data_wdata_in[BIT_BANK_HIGH:BIT_BANK_LOW];
        end
    end

    // only power-on forces the low-active flags high
    always_ff @(posedge ref_clk_in) begin
        if (rst_in && power_on_in) begin
            watchdog_expiry_flag_n <= 1'b1;
            sleep_flag_n <= 1'b1;
        end else begin
            // instruction writes never reach these bits
            if (watchdog_timeout_in) begin
                watchdog_expiry_flag_n <= 1'b0;
            end else if (watchdog_kick_op_in || sleep_op_in) begin
                watchdog_expiry_flag_n <= 1'b1;
            end
            if (sleep_op_in) begin
                sleep_flag_n <= 1'b0;
            end else if (watchdog_kick_op_in) begin
                sleep_flag_n <= 1'b1;
            end
        end
    end

    // arithmetic flags keep their value through resets
    always_ff @(posedge ref_clk_in) begin
        if (!rst_in) begin
            if (updates_zdc) begin
                zero_flag <= next_zero;
            end else if (flags_wr) begin
                zero_flag <= data_wdata_in[BIT_ZERO];
            end
            if (updates_zdc && alu_op_in != ALU_LOGIC) begin
                nibble_overflow_flag <= next_nibble;
            end else if (flags_wr && !updates_zdc) begin
                nibble_overflow_flag <= data_wdata_in[BIT_NIBBLE];
            end
            if (updates_carry) begin
                carry_flag <= next_carry;
            end else if (flags_wr && !updates_zdc) begin
                carry_flag <= data_wdata_in[BIT_CARRY];
            end
        end
    end

    assign core_flags_out = {upper_page_select, bank_select_pair, watchdog_expiry_flag_n,
                             sleep_flag_n, zero_flag, nibble_overflow_flag, carry_flag};
endmodule

/* File: tb/core_exec_model.sv */
// execution-side model issuing watchdog kick, sleep and time-out pulses
// assumes commands change at the falling edge, nonblocking
`timescale 1ns/10ps
module core_exec_model (
    input wire logic clk_in,
    input wire logic [1:0] cmd_in,
    output logic kick_out = 1'b0,
    output logic sleep_out = 1'b0,
    output logic timeout_out = 1'b0
);
    // each output stays high for as many cycles as cmd_in holds its command
    always @(negedge clk_in) begin
        kick_out <= (cmd_in == 2'h1);
        sleep_out <= (cmd_in == 2'h2);
        timeout_out <= (cmd_in == 2'h3);
    end
endmodule

/* File: tb/core_mms_properties.sv */
// assertions on the core memory map and flags register ports
// assumes bind onto core_memory_map_status, one clock domain
`timescale 1ns/10ps
module core_mms_checker import core_mem_pkg::*; #(parameter int PROG_WORDS = 512) (
    input wire logic ref_clk_in, rst_in, power_on_in, irq_take_in,
    input wire logic [12:0] pc_out, fetch_addr_out,
    input wire logic [6:0] data_addr_in,
    input wire logic data_wr_in, watchdog_kick_op_in, sleep_op_in, watchdog_timeout_in,
    input wire alu_op_t alu_op_in,
    input wire logic [7:0] alu_a_in, alu_b_in, alu_result_out, core_flags_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    logic [8:0] sum9;
    assign sum9 = {1'b0, alu_a_in} + {1'b0, alu_b_in};
    pc_start_a: assert property ($fell(rst_in) |-> pc_out == RESET_VECTOR)
        else $error("pc not at start");
    irq_vector_a: assert property (irq_take_in |=> pc_out == IRQ_VECTOR)
        else $error("pc not at irq vector");
    fetch_wrap_a: assert property (fetch_addr_out == 13'(pc_out % PROG_WORDS))
        else $error("fetch not wrapped");
    select_reset_a: assert property ($fell(rst_in) |-> core_flags_out[7:5] == 3'h0)
        else $error("select bits not cleared");
    power_flags_a: assert property ($fell(rst_in) && $past(power_on_in) |-> core_flags_out[4:3] == 2'h3)
        else $error("power flags not set");
    protect_bits_a: assert property (data_wr_in && data_addr_in == FLAGS_ADDR && !watchdog_kick_op_in
        && !sleep_op_in && !watchdog_timeout_in |=> $stable(core_flags_out[4:3]))
        else $error("power flags written");
    timeout_flag_a: assert property (watchdog_timeout_in |=> !core_flags_out[BIT_WDT_N])
        else $error("timeout flag not cleared");
    sleep_flags_a: assert property (sleep_op_in && !watchdog_timeout_in |=> core_flags_out[4:3] == 2'h2)
        else $error("sleep flags wrong");
    zero_flag_a: assert property (alu_op_in inside {ALU_ADD, ALU_SUB, ALU_LOGIC}
        |=> core_flags_out[BIT_ZERO] == ($past(alu_result_out) == 8'h00))
        else $error("zero flag wrong");
    add_carry_a: assert property (alu_op_in == ALU_ADD |-> alu_result_out == sum9[7:0]
        ##1 core_flags_out[BIT_CARRY] == $past(sum9[8]))
        else $error("add carry wrong");
    rotate_carry_a: assert property (alu_op_in == ALU_RRF |=> core_flags_out[0] == $past(alu_a_in[0]))
        else $error("rotate carry wrong");
    cover property (irq_take_in);
    cover property (sleep_op_in);
    cover property (alu_op_in == ALU_SUB && sum9[8]);
endmodule
bind core_memory_map_status core_mms_checker #(.PROG_WORDS(PROG_WORDS)) i_core_mms_checker (
    .ref_clk_in, .rst_in, .power_on_in, .irq_take_in, .pc_out, .fetch_addr_out, .data_addr_in,
    .data_wr_in, .watchdog_kick_op_in, .sleep_op_in, .watchdog_timeout_in, .alu_op_in,
    .alu_a_in, .alu_b_in, .alu_result_out, .core_flags_out);

/* File: tb/tb_top.sv */
// self-checking bench for the core memory map and flags block
// assumes the default 512-word program space
`timescale 1ns/10ps
module tb_top;
    import core_mem_pkg::*;
    logic ref_clk_in = 1'b0, rst_in = 1'b1, power_on_in = 1'b1, pc_load_in = 1'b0;
    logic pc_advance_in = 1'b0, irq_take_in = 1'b0, data_wr_in = 1'b0, alu_carry_in = 1'b0;
    logic [12:0] pc_load_value_in = 13'h0000, pc_out, fetch_addr_out;
    logic [6:0] data_addr_in = 7'h00;
    logic [7:0] data_wdata_in = 8'h00, alu_a_in = 8'h00, alu_b_in = 8'h00;
    logic [7:0] data_rdata_out, alu_result_out, core_flags_out;
    logic data_hit_out, watchdog_kick_op_in, sleep_op_in, watchdog_timeout_in;
    logic [1:0] cmd = 2'h0;
    alu_op_t alu_op_in = ALU_NONE;
    int err_count = 0;
    int total_checks = 0;
    typedef struct {alu_op_t op; logic [7:0] a, b; logic cin; logic [7:0] res; logic [2:0] fl, m;} row_t;
    row_t rows[9] = '{'{ALU_ADD, 8'h0f, 8'h01, 1'b0, 8'h10, 3'h2, 3'h7},
        '{ALU_ADD, 8'hff, 8'h01, 1'b0, 8'h00, 3'h7, 3'h7}, '{ALU_ADD, 8'h12, 8'h34, 1'b0, 8'h46, 3'h0, 3'h7},
        '{ALU_SUB, 8'h05, 8'h05, 1'b0, 8'h00, 3'h7, 3'h7}, '{ALU_SUB, 8'h03, 8'h05, 1'b0, 8'hfe, 3'h0, 3'h7},
        '{ALU_LOGIC, 8'h00, 8'h00, 1'b0, 8'h00, 3'h4, 3'h4}, '{ALU_RRF, 8'h01, 8'h00, 1'b0, 8'h00, 3'h1, 3'h1},
        '{ALU_RLF, 8'h80, 8'h00, 1'b1, 8'h01, 3'h1, 3'h1}, '{ALU_RLF, 8'h7f, 8'h00, 1'b0, 8'hfe, 3'h0, 3'h1}};
    always #12.5 ref_clk_in = ~ref_clk_in;
    core_memory_map_status i_core_memory_map_status (.ref_clk_in, .rst_in, .power_on_in, .pc_load_in,
        .pc_load_value_in, .pc_advance_in, .irq_take_in, .pc_out, .fetch_addr_out, .data_addr_in,
        .data_wr_in, .data_wdata_in, .data_rdata_out, .data_hit_out, .alu_op_in, .alu_a_in, .alu_b_in,
        .alu_carry_in, .alu_result_out, .watchdog_kick_op_in, .sleep_op_in, .watchdog_timeout_in,
        .core_flags_out);
    core_exec_model i_core_exec_model (.clk_in(ref_clk_in), .cmd_in(cmd), .kick_out(watchdog_kick_op_in),
        .sleep_out(sleep_op_in), .timeout_out(watchdog_timeout_in));
    task automatic chk(string n, logic [12:0] e, logic [12:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task final_report;
        if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(logic [6:0] a, logic [7:0] d);
        @(negedge ref_clk_in);
        data_addr_in = a;
        data_wdata_in = d;
        data_wr_in = 1'b1;
        @(negedge ref_clk_in);
        data_wr_in = 1'b0;
    endtask
    task automatic rd(logic [6:0] a, logic [7:0] e);
        @(negedge ref_clk_in);
        data_addr_in = a;
        #1 chk("rdata", 13'(e), 13'(data_rdata_out));
    endtask
    // nonblocking so the model sees the command one edge later, race free
    task automatic ev(logic [1:0] c, logic [1:0] e);
        @(negedge ref_clk_in) cmd <= c;
        @(negedge ref_clk_in) cmd <= 2'h0;
        repeat (2) @(negedge ref_clk_in);
        chk("power_flags", 13'(e), 13'(core_flags_out[4:3]));
    endtask
    initial begin
        repeat (5) @(negedge ref_clk_in);
        rst_in = 1'b0;
        power_on_in = 1'b0;
        #1 chk("pc", RESET_VECTOR, pc_out);
        chk("flags_hi", 13'h03, 13'(core_flags_out[7:3]));
        foreach (rows[i]) begin
            @(negedge ref_clk_in);
            alu_op_in = rows[i].op;
            alu_a_in = rows[i].a;
            alu_b_in = rows[i].b;
            alu_carry_in = rows[i].cin;
            #1 chk("alu_res", 13'(rows[i].res), 13'(alu_result_out));
            @(negedge ref_clk_in) alu_op_in = ALU_NONE;
            chk("alu_flags", 13'(rows[i].fl & rows[i].m), 13'(core_flags_out[2:0] & rows[i].m));
        end
        alu_op_in = ALU_ADD;
        alu_a_in = 8'h00;
        alu_b_in = 8'h00;
        wr(FLAGS_ADDR, 8'h1f);
        alu_op_in = ALU_NONE;
        rd(FLAGS_ADDR, 8'h1c);
        wr(FLAGS_ADDR, 8'h05);
        rd(FLAGS_ADDR, 8'h1d);
        wr(7'h7f, 8'h3c);
        wr(POINTER_ADDR, 8'h7f);
        rd(INDIRECT_ADDR, 8'h3c);
        wr(GPR_BASE, 8'ha5);
        rd(GPR_BASE, 8'ha5);
        rd(7'h05, 8'h00);
        chk("hit", 13'h0, 13'(data_hit_out));
        @(negedge ref_clk_in) {pc_load_in, pc_load_value_in} = {1'b1, 13'h1fff};
        @(negedge ref_clk_in) pc_load_in = 1'b0;
        chk("pc", 13'h1fff, pc_out);
        chk("fetch", 13'h01ff, fetch_addr_out);
        pc_advance_in = 1'b1;
        @(negedge ref_clk_in) chk("pc", 13'h0000, pc_out);
        irq_take_in = 1'b1;
        @(negedge ref_clk_in) {irq_take_in, pc_advance_in} = 2'b00;
        chk("pc", IRQ_VECTOR, pc_out);
        ev(2'h3, 2'h1);
        ev(2'h2, 2'h2);
        ev(2'h1, 2'h3);
        ev(2'h3, 2'h1);
        wr(FLAGS_ADDR, 8'h20);
        rd(GPR_BASE, 8'h00);
        @(negedge ref_clk_in) rst_in = 1'b1;
        @(negedge ref_clk_in) rst_in = 1'b0;
        chk("flags", 13'h08, 13'(core_flags_out));
        final_report();
    end
endmodule
